// file: hdl/pfs_params.svh
// constants of the pin function select block: offsets, reset values, codes, timing
// assumes a 32-bit axi4-lite bus and 16-bit select registers in the low half of each word
`ifndef PFS_PARAMS_SVH
`define PFS_PARAMS_SVH

// byte offsets of the select registers
`define PFS_OFF_C 32'h0000_0000
`define PFS_OFF_D 32'h0000_0004
`define PFS_OFF_E 32'h0000_0008
`define PFS_OFF_F 32'h0000_000C
`define PFS_OFF_G 32'h0000_0010

// register indices out of the address decoder
`define PFS_IDX_C 3'h0
`define PFS_IDX_D 3'h1
`define PFS_IDX_E 3'h2
`define PFS_IDX_F 3'h3
`define PFS_IDX_G 3'h4
`define PFS_IDX_NONE 3'h7

// two-bit mode field codes
`define PFS_MD_ALT 2'h0
`define PFS_MD_OUT 2'h1
`define PFS_MD_PULL 2'h2
`define PFS_MD_NOPULL 2'h3

// reset values
`define PFS_CDE_RST 16'h0000
`define PFS_F_RST_HI 14'h2AAA
`define PFS_F_RST_LO 14'h0000
`define PFS_G_RST_HI 12'hAAA
`define PFS_G_RST_LO 12'h800
`define PFS_G_RSV_ONES 4'hA
`define PFS_RSV_ZERO 1'h0
`define PFS_RD_PAD 16'h0000

// pins that exist and pins able to drive, per port c, d, e, f, g
`define PFS_PIN_ALL 8'hFF
`define PFS_PIN_F 8'h7F
`define PFS_PIN_G 8'h3F
`define PFS_OUT_F 8'h7D
`define PFS_OUT_G 8'h00

// axi responses
`define PFS_RESP_OKAY 2'h0
`define PFS_RESP_SLVERR 2'h2

// cycles for the strap synchroniser to fill before the load
`define PFS_SYNC_WAIT 2'h2

`endif

// file: hdl/pfs_pkg.sv
// types shared by the pin function select block
// assumes nothing beyond the params header
package pfs_pkg;
   typedef logic [15:0] pfs_reg_t;
   typedef enum logic [1:0] {PFS_WAIT, PFS_LOAD, PFS_RUN} pfs_init_e;
endpackage

// file: hdl/pfs_port_decode.sv
// per-pin decode of one port's mode fields into pad controls, all outputs registered
// assumes mode fields come from the select registers on the same clock
`timescale 1ns/1ps
`include "pfs_params.svh"
module pfs_port_decode
#(
   parameter int PINS = 8,
   parameter logic [PINS-1:0] PIN_MASK = '1,
   parameter logic [PINS-1:0] OUT_MASK = '1
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [2*PINS-1:0] mode,
   input wire logic [PINS-1:0] port_data,
   input wire logic [PINS-1:0] alt_out,
   input wire logic [PINS-1:0] alt_oe,
   output logic [PINS-1:0] alt_sel,
   output logic [PINS-1:0] port_oe,
   output logic [PINS-1:0] pull_up_en,
   output logic [PINS-1:0] pad_out,
   output logic [PINS-1:0] pad_oe
);

   logic [PINS-1:0] alt_d;
   logic [PINS-1:0] out_d;
   logic [PINS-1:0] pull_d;
   logic [PINS-1:0] pado_d;
   logic [PINS-1:0] padoe_d;

   if (PINS < 1 || PINS > 16)
   begin : g_bad
      $error("pfs_port_decode: PINS must be 1 to 16");
   end

   // field decode per pin, absent pins stay quiet except pad_out, which follows alt_out
   for (genvar i = 0; i < PINS; i++)
   begin : g_pin
      wire logic [1:0] md = mode[2*i +: 2];
      assign alt_d[i] = PIN_MASK[i] & (md == `PFS_MD_ALT); // R1 R15
      assign out_d[i] = PIN_MASK[i] & OUT_MASK[i] & (md == `PFS_MD_OUT); // R1 R9 R15
      assign pull_d[i] = PIN_MASK[i] & (md == `PFS_MD_PULL); // R1 R15
      assign pado_d[i] = out_d[i] ? port_data[i] : alt_out[i]; // R14
      assign padoe_d[i] = out_d[i] | (alt_d[i] & alt_oe[i]); // R13 R14
   end

   // register the pad controls
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         alt_sel <= '0;
         port_oe <= '0;
         pull_up_en <= '0;
         pad_out <= '0;
         pad_oe <= '0;
      end
      else
      begin
         alt_sel <= alt_d;
         port_oe <= out_d;
         pull_up_en <= pull_d;
         pad_out <= pado_d;
         pad_oe <= padoe_d;
      end
   end

endmodule

// file: hdl/pfs_top.sv
// pin function select for ports c to g: five select registers on axi4-lite and pad decode
// assumes clk at 50 MHz, sys_rst is the power-on reset, manual_rst and the strap are pins
//
// Overview of operation
// R1: mode field 00 alternate, 01 output, 10 input pulled up, 11 input no pull.
// R2: port c register is 16-bit read/write, pin n at bits 2n+1:2n, resets zero.
// R3: port d register is 16-bit read/write, eight fields, resets zero.
// R4: port e register is 16-bit read/write, eight fields, resets zero.
// R5: power-on reset loads port f with AAAA if strap high, else 0000.
// R6: port f and g keep contents through manual reset, standby and sleep.
// R7: port f bit 15 reads the strap level; software writes the same.
// R8: port f bit 14 reads zero; software writes zero.
// R9: software never sets output code on port f pin 1 or port g pins.
// R10: power-on reset loads port g with AAAA if strap high, else A800.
// R11: port g bits 15 and 13 read one; software writes zero.
// R12: port g bits 14 and 12 read zero; software writes zero.
// R13: function and direction are chosen per pin regardless of operating mode.
// R14: output mode lets the data bit drive the pin; otherwise data has no effect.
// R15: each pin gives alternate select, output enable and pull-up enable (code 10).
// R16: read-only reserved bits ignore writes.
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "pfs_params.svh"
module pfs_top
#(
   parameter int PINS = 8
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic manual_rst,
   input wire logic debug_mode_strap,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [5*PINS-1:0] port_data,
   input wire logic [5*PINS-1:0] alt_out,
   input wire logic [5*PINS-1:0] alt_oe,
   output logic [5*PINS-1:0] alt_sel,
   output logic [5*PINS-1:0] port_oe,
   output logic [5*PINS-1:0] pull_up_en,
   output logic [5*PINS-1:0] pad_out,
   output logic [5*PINS-1:0] pad_oe
);

   if (PINS != 8)
   begin : g_bad
      $error("pfs_top: sixteen-bit select registers hold exactly eight pins");
   end

   // address decode shared by the write and read paths
   function automatic logic [2:0] pfs_sel(input logic [31:0] a);
      case (a)
         `PFS_OFF_C: pfs_sel = `PFS_IDX_C;
         `PFS_OFF_D: pfs_sel = `PFS_IDX_D;
         `PFS_OFF_E: pfs_sel = `PFS_IDX_E;
         `PFS_OFF_F: pfs_sel = `PFS_IDX_F;
         `PFS_OFF_G: pfs_sel = `PFS_IDX_G;
         default: pfs_sel = `PFS_IDX_NONE;
      endcase
   endfunction

   // byte-lane merge of a write into a 16-bit register
   function automatic logic [15:0] pfs_merge(input logic [15:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
      pfs_merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
   endfunction

   logic mrst_s1_q;
   logic mrst_s2_q;
   logic strap_s1_q;
   logic strap_s2_q;
   pfs_pkg::pfs_init_e state_q;
   logic [1:0] cnt_q;
   pfs_pkg::pfs_reg_t c_q;
   pfs_pkg::pfs_reg_t d_q;
   pfs_pkg::pfs_reg_t e_q;
   logic [13:0] f_q;
   logic [11:0] g_q;
   logic aw_have_q;
   logic [31:0] aw_addr_q;
   logic w_have_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;

   // two-flop synchronisers for the pin inputs
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         mrst_s1_q <= 1'b0;
         mrst_s2_q <= 1'b0;
         strap_s1_q <= 1'b0;
         strap_s2_q <= 1'b0;
      end
      else
      begin
         mrst_s1_q <= manual_rst;
         mrst_s2_q <= mrst_s1_q;
         strap_s1_q <= debug_mode_strap;
         strap_s2_q <= strap_s1_q;
      end
   end

   // after power-on release wait for the strap to settle, then load f and g once
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_q <= pfs_pkg::PFS_WAIT;
         cnt_q <= 2'h0;
      end
      else
      begin
         unique case (state_q)
            pfs_pkg::PFS_WAIT:
            begin
               if (cnt_q == `PFS_SYNC_WAIT)
                  state_q <= pfs_pkg::PFS_LOAD;
               else
                  cnt_q <= cnt_q + 2'h1;
            end
            pfs_pkg::PFS_LOAD: state_q <= pfs_pkg::PFS_RUN;
            pfs_pkg::PFS_RUN: state_q <= pfs_pkg::PFS_RUN;
         endcase
      end
   end

   wire logic init_load = (state_q == pfs_pkg::PFS_LOAD);

   // read views; reserved bits are built here, never stored
   wire pfs_pkg::pfs_reg_t f_read = {strap_s2_q, `PFS_RSV_ZERO, f_q}; // R7 R8 R16
   wire pfs_pkg::pfs_reg_t g_read = {`PFS_G_RSV_ONES, g_q}; // R11 R12 R16

   // write path decode
   wire logic aw_take = s_axi_awvalid & s_axi_awready;
   wire logic w_take = s_axi_wvalid & s_axi_wready;
   wire logic b_done = s_axi_bvalid & s_axi_bready;
   wire logic wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
   wire logic [2:0] wr_idx = pfs_sel(aw_addr_q);
   wire logic wr_c = wr_fire & (wr_idx == `PFS_IDX_C);
   wire logic wr_d = wr_fire & (wr_idx == `PFS_IDX_D);
   wire logic wr_e = wr_fire & (wr_idx == `PFS_IDX_E);
   wire logic wr_f = wr_fire & (wr_idx == `PFS_IDX_F);
   wire logic wr_g = wr_fire & (wr_idx == `PFS_IDX_G);
   wire pfs_pkg::pfs_reg_t f_merged = pfs_merge(f_read, w_data_q, w_strb_q);
   wire pfs_pkg::pfs_reg_t g_merged = pfs_merge(g_read, w_data_q, w_strb_q);

   // read path decode
   wire logic ar_take = s_axi_arvalid & s_axi_arready;
   wire logic r_done = s_axi_rvalid & s_axi_rready;
   wire logic [2:0] rd_idx = pfs_sel(s_axi_araddr);
   wire logic rd_err = (rd_idx == `PFS_IDX_NONE);
   wire pfs_pkg::pfs_reg_t rd_word =
      (rd_idx == `PFS_IDX_C) ? c_q :
      (rd_idx == `PFS_IDX_D) ? d_q :
      (rd_idx == `PFS_IDX_E) ? e_q :
      (rd_idx == `PFS_IDX_F) ? f_read :
      (rd_idx == `PFS_IDX_G) ? g_read : `PFS_CDE_RST;

   // ports c, d, e: cleared by power-on and manual reset
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         c_q <= `PFS_CDE_RST; // R2
         d_q <= `PFS_CDE_RST; // R3
         e_q <= `PFS_CDE_RST; // R4
      end
      else if (mrst_s2_q)
      begin
         c_q <= `PFS_CDE_RST;
         d_q <= `PFS_CDE_RST;
         e_q <= `PFS_CDE_RST;
      end
      else
      begin
         if (wr_c)
            c_q <= pfs_merge(c_q, w_data_q, w_strb_q); // R2
         if (wr_d)
            d_q <= pfs_merge(d_q, w_data_q, w_strb_q); // R3
         if (wr_e)
            e_q <= pfs_merge(e_q, w_data_q, w_strb_q); // R4
      end
   end

   // ports f, g: strap-dependent load after power-on only, manual reset ignored
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         f_q <= `PFS_F_RST_LO;
         g_q <= `PFS_G_RST_LO;
      end
      else if (init_load)
      begin
         f_q <= strap_s2_q ? `PFS_F_RST_HI : `PFS_F_RST_LO; // R5 R6
         g_q <= strap_s2_q ? `PFS_G_RST_HI : `PFS_G_RST_LO; // R10 R6
      end
      else
      begin
         if (wr_f)
            f_q <= f_merged[13:0]; // R8 R16
         if (wr_g)
            g_q <= g_merged[11:0]; // R11 R12 R16
      end
   end

   // write address channel
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_axi_awready <= 1'b0;
         aw_have_q <= 1'b0;
         aw_addr_q <= '0;
      end
      else if (aw_take)
      begin
         s_axi_awready <= 1'b0;
         aw_have_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end
      else
      begin
         if (wr_fire)
            aw_have_q <= 1'b0;
         if (init_load | b_done)
            s_axi_awready <= 1'b1;
      end
   end

   // write data channel
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_axi_wready <= 1'b0;
         w_have_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end
      else if (w_take)
      begin
         s_axi_wready <= 1'b0;
         w_have_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end
      else
      begin
         if (wr_fire)
            w_have_q <= 1'b0;
         if (init_load | b_done)
            s_axi_wready <= 1'b1;
      end
   end

   // write response, slave error on an unmapped address
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PFS_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wr_idx == `PFS_IDX_NONE) ? `PFS_RESP_SLVERR : `PFS_RESP_OKAY;
      end
      else if (b_done)
         s_axi_bvalid <= 1'b0;
   end

   // read channel, one read in flight
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `PFS_RESP_OKAY;
      end
      else if (ar_take)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {`PFS_RD_PAD, rd_word};
         s_axi_rresp <= rd_err ? `PFS_RESP_SLVERR : `PFS_RESP_OKAY;
      end
      else if (r_done)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
      else if (init_load)
         s_axi_arready <= 1'b1;
   end

   // mode words and pad capability per port c, d, e, f, g
   pfs_pkg::pfs_reg_t mode_w [5];
   assign mode_w[0] = c_q;
   assign mode_w[1] = d_q;
   assign mode_w[2] = e_q;
   assign mode_w[3] = f_read;
   assign mode_w[4] = g_read;

   localparam logic [7:0] PIN_MASKS [5] = '{`PFS_PIN_ALL, `PFS_PIN_ALL, `PFS_PIN_ALL, `PFS_PIN_F, `PFS_PIN_G};
   localparam logic [7:0] OUT_MASKS [5] = '{`PFS_PIN_ALL, `PFS_PIN_ALL, `PFS_PIN_ALL, `PFS_OUT_F, `PFS_OUT_G};

   // one decoder per port, each pin independent of the others and of chip mode
   for (genvar p = 0; p < 5; p++)
   begin : g_port
      pfs_port_decode
      #(
         .PINS(PINS),
         .PIN_MASK(PIN_MASKS[p]),
         .OUT_MASK(OUT_MASKS[p]) // R9
      )
      u_dec
      (
         .clk(clk),
         .sys_rst(sys_rst),
         .mode(mode_w[p]), // R13
         .port_data(port_data[p*PINS +: PINS]), // R14
         .alt_out(alt_out[p*PINS +: PINS]),
         .alt_oe(alt_oe[p*PINS +: PINS]),
         .alt_sel(alt_sel[p*PINS +: PINS]), // R15
         .port_oe(port_oe[p*PINS +: PINS]),
         .pull_up_en(pull_up_en[p*PINS +: PINS]),
         .pad_out(pad_out[p*PINS +: PINS]),
         .pad_oe(pad_oe[p*PINS +: PINS])
      );
   end

endmodule

// file: testbench/pfs_top_checker.sv
// assertions on the pin select block: bus handshakes and pad decode
// assumes binding to pfs_top, seeing its ports only
`timescale 1ns/1ps
module pfs_top_checker
#(
   parameter int PINS = 8
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [5*PINS-1:0] alt_sel,
   input wire logic [5*PINS-1:0] port_oe,
   input wire logic [5*PINS-1:0] pull_up_en,
   input wire logic [5*PINS-1:0] pad_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // write response steps
   sequence s_bwait;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   sequence s_bdone;
      s_axi_bvalid && s_axi_bready;
   endsequence
   // pad decode
   a_one_mode:
      assert property ((alt_sel & port_oe | alt_sel & pull_up_en | port_oe & pull_up_en) == '0)
      else $error("pin in two modes");
   a_input_no_oe:
      assert property (port_oe[4*PINS+:PINS] == '0 && !port_oe[3*PINS+1])
      else $error("input-only pin enabled");
   a_absent_off:
      assert property ({alt_sel[4*PINS+6+:2], alt_sel[3*PINS+7], pull_up_en[4*PINS+6+:2]} == '0)
      else $error("absent pin selected");
   a_oe_to_pad:
      assert property ((port_oe & ~pad_oe) == '0)
      else $error("output pin not driven");
   // bus handshakes
   a_b_hold:
      assert property (s_bwait |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_b_release:
      assert property (s_bdone |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write not closed");
   a_w_busy:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   a_r_answer:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000)
      else $error("read not answered");
   a_r_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp) && !s_axi_arready)
      else $error("read data dropped");
endmodule

bind pfs_top pfs_top_checker #(.PINS(PINS)) u_chk
(
   .clk, .sys_rst, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
   .alt_sel, .port_oe, .pull_up_en, .pad_oe
);

// file: testbench/pfs_top_tb.sv
// self-checking bench for the pin select block over axi4-lite
// assumes pfs_top with eight pins per port and the header offsets
`timescale 1ns/1ps
`include "pfs_params.svh"
module pfs_top_tb;
   localparam logic [1:0] ok = `PFS_RESP_OKAY;
   localparam logic [1:0] err = `PFS_RESP_SLVERR;
   logic clk = 1'b0, sys_rst = 1'b1, manual_rst = 1'b0, debug_mode_strap = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
   logic [3:0] s_axi_wstrb = 4'h3;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [39:0] port_data = '0, alt_out = '0, alt_oe = '0;
   logic [39:0] alt_sel, port_oe, pull_up_en, pad_out, pad_oe;
   logic [15:0] pat [3] = '{16'hFFFF, 16'h1B1B, 16'hE4E4};
   int n_mismatch = 0, n_tests = 0, cyc = 0;

   pfs_top #(.PINS(8)) uut
   (
      .clk, .sys_rst, .manual_rst, .debug_mode_strap, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .port_data, .alt_out, .alt_oe, .alt_sel, .port_oe,
      .pull_up_en, .pad_out, .pad_oe
   );

   // 50 MHz clock
   always #10 clk = ~clk;

   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_mismatch++;
         conclude();
      end
   end

   task automatic conclude;
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // write: address and data offered together, each released when taken
   task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic [1:0] er);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", {38'h0, er}, {38'h0, s_axi_bresp});
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk("rdata", {8'h0, e}, {8'h0, s_axi_rdata});
      chk("rresp", {38'h0, er}, {38'h0, s_axi_rresp});
   endtask

   // power-on reset with a given strap level
   task automatic por(input logic s);
      sys_rst <= 1'b1;
      debug_mode_strap <= s;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge clk);
   endtask

   // main sequence
   initial
   begin
      por(1'b0);
      rd(`PFS_OFF_F, 32'h0000_0000, ok);
      rd(`PFS_OFF_G, 32'h0000_A800, ok);
      por(1'b1);
      rd(`PFS_OFF_F, 32'h0000_AAAA, ok);
      rd(`PFS_OFF_G, 32'h0000_AAAA, ok);
      for (int i = 0; i < 3; i++)
      begin
         rd(4 * i, 32'h0, ok);
         wr(4 * i, pat[i], ok);
         rd(4 * i, {16'h0000, pat[i]}, ok);
      end
      // upper byte lane only: low byte of port d must survive
      s_axi_wstrb <= 4'h2;
      wr(`PFS_OFF_D, 16'h0000, ok);
      s_axi_wstrb <= 4'h3;
      rd(`PFS_OFF_D, 32'h0000_001B, ok);
      wr(`PFS_OFF_F, 16'hFFFF, ok);
      rd(`PFS_OFF_F, 32'h0000_BFFF, ok);
      wr(`PFS_OFF_G, 16'hFFFF, ok);
      rd(`PFS_OFF_G, 32'h0000_AFFF, ok);
      wr(32'h0000_0014, 16'h1234, err);
      rd(32'h0000_0014, 32'h0, err);
      // every code on port c, output requested on f pins 0 and 1
      port_data <= 40'h0F;
      alt_out <= 40'hF0;
      alt_oe <= 40'hFF;
      wr(`PFS_OFF_C, 16'h1B1B, ok);
      wr(`PFS_OFF_F, 16'h0005, ok);
      repeat (2) @(posedge clk);
      chk("alt_sel", 40'h88, alt_sel & 40'hFF);
      chk("port_oe", 40'h44, port_oe & 40'hFF);
      chk("pull_up_en", 40'h22, pull_up_en & 40'hFF);
      chk("pad_out", 40'hB4, pad_out & 40'hFF);
      chk("pad_oe", 40'hCC, pad_oe & 40'hFF);
      chk("port_oe_f", 40'h01, port_oe >> 24 & 40'hFF);
      // manual reset clears c but keeps f
      manual_rst <= 1'b1;
      repeat (5) @(posedge clk);
      manual_rst <= 1'b0;
      repeat (3) @(posedge clk);
      rd(`PFS_OFF_C, 32'h0, ok);
      rd(`PFS_OFF_F, 32'h0000_8005, ok);
      por(1'b1);
      rd(`PFS_OFF_F, 32'h0000_AAAA, ok);
      conclude();
   end
endmodule
